// ### hw/uls_map.svh
// register map, field positions and constants for the upper line status logic
//
// Summary of operation
// - error summary bit sets when a character with an error is stored, clears when none is stored
// - reading line_status clears the error summary bit
// - non-FIFO: transmitter_empty is 1 only with holding and shift registers empty
// - FIFO mode: transmitter_empty is 1 when transmit FIFO and shift register are empty
// - non-FIFO: holding_empty sets when a character moves into the shift register
// - non-FIFO: holding_empty clears in the cycle the host writes a character
// - FIFO mode: holding_empty sets on empty transmit FIFO, clears on any write
// - interrupt request while holding_empty is set and its enable is set
// - break_seen sets after the receive line is low for one whole frame time
// - one break character enters the receive FIFO per break, however long
// - frame_error sets when a received character lacks a valid stop bit
// - FIFO mode: frame_error follows the flag stored with the head character
// - after reset break_seen, frame_error and error summary read 0
`ifndef ULS_MAP_SVH
`define ULS_MAP_SVH

`define ULS_OFF_LINE_STATUS  8'h00
`define ULS_OFF_CONTROL      8'h04
`define ULS_OFF_TX_DATA      8'h08
`define ULS_OFF_RX_DATA      8'h0C
`define ULS_OFF_IRQ_STATUS   8'h10
`define ULS_OFF_IRQ_MASK     8'h14

`define ULS_LS_SUMMARY       7
`define ULS_LS_TX_EMPTY      6
`define ULS_LS_HOLD_EMPTY    5
`define ULS_LS_BREAK         4
`define ULS_LS_FRAME         3

`define ULS_CTL_FIFO_EN      0
`define ULS_CTL_THR_IE       1
`define ULS_CTL_WLEN_LO      2
`define ULS_CTL_PARITY       4
`define ULS_CTL_TWO_STOP     5
`define ULS_CTL_W            6
`define ULS_CTL_RESET        6'h00

`define ULS_IRQ_HOLD         0
`define ULS_IRQ_BREAK        1
`define ULS_IRQ_FRAME        2
`define ULS_IRQ_SUMMARY      3
`define ULS_IRQ_W            4
`define ULS_IRQ_RESET        4'h0

`define ULS_FIFO_DEPTH       16
`define ULS_MIN_DATA_BITS    4'h5

`endif

// ### hw/uls_pkg.sv
// types shared by the upper line status logic
package uls_pkg;

    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } uls_rx_entry_type;

    typedef enum logic [1:0] {
        BRK_IDLE,
        BRK_COUNT,
        BRK_HELD
    } uls_brk_state_type;

endpackage

// ### hw/uls_rx_fifo.sv
// receive FIFO holding each character with its error flags
`timescale 1ns/1ps
`default_nettype none
`include "uls_map.svh"
module uls_rx_fifo
    import uls_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    uls_rx_if.fifo    port
);
    localparam int AW = $clog2(`ULS_FIFO_DEPTH);

    uls_rx_entry_type   mem [`ULS_FIFO_DEPTH];
    logic [AW-1:0]      wr_ptr_reg;
    logic [AW-1:0]      rd_ptr_reg;
    logic [AW:0]        count_reg;
    logic [AW:0]        err_count_reg;
    logic               head_load_reg;
    logic               do_push;
    logic               do_pop;
    logic               push_err;
    logic               pop_err;

    assign do_pop   = port.pop && (count_reg != '0);
    assign do_push  = port.push && (!port.full || do_pop);
    assign push_err = do_push && (port.push_entry.brk || port.push_entry.fe
                                  || port.push_entry.pe);
    assign pop_err  = do_pop && (port.head.brk || port.head.fe || port.head.pe);

    assign port.head        = mem[rd_ptr_reg];
    assign port.empty       = (count_reg == '0);
    assign port.full        = (count_reg == (AW+1)'(`ULS_FIFO_DEPTH));
    assign port.head_load   = head_load_reg;
    assign port.err_present = (err_count_reg != '0);
    assign port.err_push    = push_err;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= port.push_entry;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || port.flush) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            err_count_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg     <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
            err_count_reg <= err_count_reg + (AW+1)'(push_err) - (AW+1)'(pop_err);
        end
    end

    // pulse in the cycle a new character first shows at the head
    always_ff @(posedge clk) begin
        if (rst || port.flush) begin
            head_load_reg <= 1'b0;
        end else begin
            head_load_reg <= do_pop ? ((count_reg > (AW+1)'(1)) || do_push)
                                    : (do_push && (count_reg == '0));
        end
    end
endmodule
`default_nettype wire

// ### hw/uls_rx_if.sv
// carrier between the status logic and its receive FIFO
`timescale 1ns/1ps
`default_nettype none
interface uls_rx_if;
    import uls_pkg::*;
    logic             push;
    uls_rx_entry_type push_entry;
    logic             pop;
    logic             flush;
    uls_rx_entry_type head;
    logic             empty;
    logic             full;
    logic             head_load;
    logic             err_present;
    logic             err_push;

    modport fifo (input push, push_entry, pop, flush,
                  output head, empty, full, head_load, err_present, err_push);
    modport user (output push, push_entry, pop, flush,
                  input head, empty, full, head_load, err_present, err_push);
endinterface
`default_nettype wire

// ### hw/uls_top.sv
// upper line status bits of one channel with APB register access
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uls_map.svh"
module uls_top
    import uls_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        rx_line,
    input  wire logic        bit_tick,
    input  wire logic        rx_char_valid,
    input  wire logic [7:0]  rx_char_data,
    input  wire logic        rx_parity_bad,
    input  wire logic        rx_stop_bit,
    output var  logic        tx_write,
    output var  logic [7:0]  tx_data,
    input  wire logic        tx_fifo_empty,
    input  wire logic        tx_shift_load,
    input  wire logic        tx_shift_busy,
    output var  logic        fifo_mode,
    output var  logic        thr_irq,
    output var  logic        irq
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        setup_phase;
    logic        access_done;
    logic        wr_done;
    logic        rd_done;
    logic        addr_hit;
    logic [31:0] rd_value;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable;
    assign wr_done     = access_done && pwrite && !pslverr_reg;
    assign rd_done     = access_done && !pwrite && !pslverr_reg;

    always_comb begin
        case (paddr)
            `ULS_OFF_LINE_STATUS, `ULS_OFF_CONTROL, `ULS_OFF_TX_DATA,
            `ULS_OFF_RX_DATA, `ULS_OFF_IRQ_STATUS, `ULS_OFF_IRQ_MASK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // no wait state: data is captured in setup so prdata comes from a flop
    assign pready  = access_done;
    assign prdata  = prdata_reg;
    assign pslverr = access_done && pslverr_reg;

    // ------------------------------------------------------------
    // control and mask registers
    // ------------------------------------------------------------
    logic [`ULS_CTL_W-1:0] control_reg;
    logic [`ULS_IRQ_W-1:0] irq_mask_reg;
    logic                  fifo_en;
    logic                  thr_ie;
    logic [3:0]            frame_bits;

    always_ff @(posedge clk) begin
        if (rst) begin
            control_reg  <= `ULS_CTL_RESET;
            irq_mask_reg <= `ULS_IRQ_RESET;
        end else if (wr_done && paddr == `ULS_OFF_CONTROL) begin
            control_reg  <= pwdata[`ULS_CTL_W-1:0];
        end else if (wr_done && paddr == `ULS_OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`ULS_IRQ_W-1:0];
        end
    end

    assign fifo_en   = control_reg[`ULS_CTL_FIFO_EN];
    assign thr_ie    = control_reg[`ULS_CTL_THR_IE];
    assign fifo_mode = fifo_en;

    // start + data + parity + stop(s)
    assign frame_bits = 4'h2 + `ULS_MIN_DATA_BITS
                      + {2'b00, control_reg[`ULS_CTL_WLEN_LO +: 2]}
                      + {3'b000, control_reg[`ULS_CTL_PARITY]}
                      + {3'b000, control_reg[`ULS_CTL_TWO_STOP]};

    // ------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------
    logic tx_write_reg;
    logic [7:0] tx_data_reg;
    logic host_tx_wr;
    logic holding_empty_reg;
    logic transmitter_empty;

    assign host_tx_wr = wr_done && paddr == `ULS_OFF_TX_DATA;

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_write_reg <= 1'b0;
            tx_data_reg  <= 8'h00;
        end else begin
            tx_write_reg <= host_tx_wr;
            if (host_tx_wr) begin
                tx_data_reg <= pwdata[7:0];
            end
        end
    end

    assign tx_write = tx_write_reg;
    assign tx_data  = tx_data_reg;

    // a host write clears the bit in its own cycle; a new character then
    // occupies the holding stage, so the write outranks a same-cycle load
    always_ff @(posedge clk) begin
        if (rst) begin
            holding_empty_reg <= 1'b1;
        end else if (host_tx_wr) begin
            holding_empty_reg <= 1'b0;
        end else if (fifo_en) begin
            if (tx_fifo_empty && !tx_write_reg) begin
                holding_empty_reg <= 1'b1;
            end
        end else if (tx_shift_load) begin
            holding_empty_reg <= 1'b1;
        end
    end

    assign transmitter_empty = fifo_en
        ? (tx_fifo_empty && !tx_write_reg && !tx_shift_busy)
        : (holding_empty_reg && !tx_shift_busy);

    assign thr_irq = holding_empty_reg && thr_ie;

    // ------------------------------------------------------------
    // break detection
    // ------------------------------------------------------------
    uls_brk_state_type brk_state_reg;
    logic [3:0]        brk_count_reg;
    logic              brk_event;

    assign brk_event = (brk_state_reg == BRK_COUNT) && bit_tick
                     && (brk_count_reg + 4'h1 == frame_bits) && !rx_line;

    always_ff @(posedge clk) begin
        if (rst) begin
            brk_state_reg <= BRK_IDLE;
            brk_count_reg <= 4'h0;
        end else begin
            case (brk_state_reg)
                BRK_IDLE: begin
                    brk_count_reg <= 4'h0;
                    if (!rx_line) begin
                        brk_state_reg <= BRK_COUNT;
                    end
                end
                BRK_COUNT: begin
                    if (rx_line) begin
                        brk_state_reg <= BRK_IDLE;
                    end else if (brk_event) begin
                        brk_state_reg <= BRK_HELD;
                    end else if (bit_tick) begin
                        brk_count_reg <= brk_count_reg + 4'h1;
                    end
                end
                BRK_HELD: begin
                    // stay until the line returns high: one break per low period
                    if (rx_line) begin
                        brk_state_reg <= BRK_IDLE;
                    end
                end
                default: brk_state_reg <= BRK_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive FIFO feed
    // ------------------------------------------------------------
    uls_rx_if rxq ();
    logic     rx_fe;
    logic     rx_dup_break;
    logic     fifo_en_d_reg;

    uls_rx_fifo u_rx_fifo (
        .clk  (clk),
        .rst  (rst),
        .port (rxq.fifo)
    );

    assign rx_fe = !rx_stop_bit;
    // the receiver also frames the low line as a zero character; drop it
    assign rx_dup_break = (brk_state_reg != BRK_IDLE) && rx_fe
                        && (rx_char_data == 8'h00);

    always_comb begin
        rxq.push       = 1'b0;
        rxq.push_entry = '0;
        if (brk_event) begin
            rxq.push           = 1'b1;
            rxq.push_entry.brk = 1'b1;
            rxq.push_entry.fe  = 1'b1;
        end else if (rx_char_valid && !rx_dup_break) begin
            rxq.push            = 1'b1;
            rxq.push_entry.fe   = rx_fe;
            rxq.push_entry.pe   = rx_parity_bad;
            rxq.push_entry.data = rx_char_data;
        end
    end

    assign rxq.pop = rd_done && paddr == `ULS_OFF_RX_DATA;

    // stale entries would carry flags of the old mode
    always_ff @(posedge clk) begin
        if (rst) begin
            fifo_en_d_reg <= 1'b0;
        end else begin
            fifo_en_d_reg <= fifo_en;
        end
    end

    assign rxq.flush = fifo_en != fifo_en_d_reg;

    // ------------------------------------------------------------
    // line status flags
    // ------------------------------------------------------------
    logic ls_read;
    logic break_seen_reg;
    logic frame_error_reg;
    logic summary_reg;
    logic brk_set;
    logic fe_set;
    logic [7:0] line_status;

    assign ls_read = rd_done && paddr == `ULS_OFF_LINE_STATUS;

    assign brk_set = fifo_en ? (rxq.head_load && rxq.head.brk) : brk_event;
    assign fe_set  = fifo_en ? (rxq.head_load && rxq.head.fe)
                             : (brk_event || (rx_char_valid && rx_fe && !rx_dup_break));

    // a read clears only what it returned; a same-cycle set still wins
    always_ff @(posedge clk) begin
        if (rst) begin
            break_seen_reg  <= 1'b0;
            frame_error_reg <= 1'b0;
            summary_reg     <= 1'b0;
        end else begin
            if (brk_set) begin
                break_seen_reg <= 1'b1;
            end else if (ls_read && prdata_reg[`ULS_LS_BREAK]) begin
                break_seen_reg <= 1'b0;
            end
            if (fe_set) begin
                frame_error_reg <= 1'b1;
            end else if (ls_read && prdata_reg[`ULS_LS_FRAME]) begin
                frame_error_reg <= 1'b0;
            end
            if (rxq.err_push) begin
                summary_reg <= 1'b1;
            end else if (ls_read && prdata_reg[`ULS_LS_SUMMARY]) begin
                summary_reg <= 1'b0;
            end else if (!rxq.err_present) begin
                summary_reg <= 1'b0;
            end
        end
    end

    assign line_status = {summary_reg, transmitter_empty, holding_empty_reg,
                          break_seen_reg, frame_error_reg, 3'b000};

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [`ULS_IRQ_W-1:0] irq_status_reg;
    logic [`ULS_IRQ_W-1:0] irq_set;
    logic [`ULS_IRQ_W-1:0] irq_clr;
    logic                  hold_empty_d_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_empty_d_reg <= 1'b1;
        end else begin
            hold_empty_d_reg <= holding_empty_reg;
        end
    end

    assign irq_set[`ULS_IRQ_HOLD]    = holding_empty_reg && !hold_empty_d_reg;
    assign irq_set[`ULS_IRQ_BREAK]   = brk_set;
    assign irq_set[`ULS_IRQ_FRAME]   = fe_set;
    assign irq_set[`ULS_IRQ_SUMMARY] = rxq.err_push;
    assign irq_clr = (wr_done && paddr == `ULS_OFF_IRQ_STATUS)
                   ? pwdata[`ULS_IRQ_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status_reg <= `ULS_IRQ_RESET;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // read data capture
    // ------------------------------------------------------------
    always_comb begin
        rd_value = 32'h0000_0000;
        case (paddr)
            `ULS_OFF_LINE_STATUS: rd_value[7:0] = line_status;
            `ULS_OFF_CONTROL:     rd_value[`ULS_CTL_W-1:0] = control_reg;
            `ULS_OFF_RX_DATA:     rd_value[7:0] = rxq.empty ? 8'h00 : rxq.head.data;
            `ULS_OFF_IRQ_STATUS:  rd_value[`ULS_IRQ_W-1:0] = irq_status_reg;
            `ULS_OFF_IRQ_MASK:    rd_value[`ULS_IRQ_W-1:0] = irq_mask_reg;
            default:              rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_value;
            pslverr_reg <= !addr_hit;
        end
    end
endmodule
`default_nettype wire

// ### test/uls_top_assertions.sv
// concurrent checks on the line status ports
`timescale 1ns/1ps
`default_nettype none
`include "uls_map.svh"
module uls_top_assertions (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        rx_line,
    input wire logic        rx_char_valid,
    input wire logic        tx_write,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_fifo_empty,
    input wire logic        tx_shift_busy,
    input wire logic        fifo_mode,
    input wire logic        thr_irq,
    input wire logic        irq
);
    // ----------------------------------------
    // access decode
    // ----------------------------------------
    wire logic ls_setup = psel && !penable && !pwrite && paddr == `ULS_OFF_LINE_STATUS;
    wire logic ls_acc   = psel && penable && !pwrite && paddr == `ULS_OFF_LINE_STATUS;
    wire logic tx_acc   = psel && penable && pwrite && paddr == `ULS_OFF_TX_DATA;
    // no receive push between the reads
    wire logic quiet    = rx_line && !rx_char_valid;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    chk_txe_busy: assert property (ls_acc |-> !(prdata[6] && $past(tx_shift_busy)))
        else $error("transmitter empty read while shift register busy");
    chk_txe_hold: assert property (ls_acc && !fifo_mode && prdata[6] |-> prdata[5])
        else $error("transmitter empty read without holding empty");
    chk_txe_fifo: assert property (ls_acc && fifo_mode |->
        prdata[6] == $past(tx_fifo_empty && !tx_write && !tx_shift_busy))
        else $error("transmitter empty wrong in fifo mode");
    chk_hold_fifo: assert property (ls_acc && fifo_mode && !$past(tx_fifo_empty) |-> !prdata[5])
        else $error("holding empty read with transmit fifo filled");
    chk_hold_write: assert property (tx_acc |=> !thr_irq)
        else $error("holding interrupt high after data write");
    chk_tx_pulse: assert property (tx_acc |=>
        tx_write && tx_data == $past(pwdata[7:0]) ##1 !tx_write)
        else $error("transmit write pulse or data wrong");
    chk_thr_cause: assert property (ls_acc && $past(thr_irq) |-> prdata[5])
        else $error("holding interrupt without holding empty");
    chk_sum_clear: assert property ((ls_setup && quiet) ##1 (ls_acc && prdata[7] && quiet)
        ##1 (ls_setup && quiet) |=> !prdata[7])
        else $error("error summary not cleared by status read");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
        !irq && !thr_irq && !tx_write)
        else $error("outputs active after reset");

    cover property (ls_acc && prdata[7]);
    cover property (ls_acc && prdata[4]);
    cover property (ls_acc && prdata[3]);
    cover property (irq);
endmodule
`default_nettype wire

// ### test/uls_top_tb.sv
// self-checking bench for the line status logic
`timescale 1ns/1ps
`default_nettype none
`include "uls_map.svh"
module uls_top_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        rx_line = 1'b1;
    logic        bit_tick = 1'b0;
    logic        rx_char_valid = 1'b0;
    logic [7:0]  rx_char_data = 8'h00;
    logic        rx_parity_bad = 1'b0;
    logic        rx_stop_bit = 1'b1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_write;
    logic [7:0]  tx_data;
    logic        tx_fifo_empty;
    logic        tx_shift_load;
    logic        tx_shift_busy;
    logic        fifo_mode;
    logic        thr_irq;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] seed = 32'hb386_8f26;
    bit          kept;
    int          errors;
    int          n_compared;
    logic [7:0]  rxq[$];

    always #25 clk = ~clk;

    uls_top DUT (.*);
    uls_tx_model partner (.*);

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout;
        errors++;
        $display("wrong value at %0t: wait ran out", $time);
        stop_test();
    endtask
    function automatic logic [7:0] rnd8();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    // keep: next setup follows at once
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input bit keep);
        int n;
        if (!kept) @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout();
        rdat = prdata;
        rerr = pslverr;
        penable <= 1'b0;
        if (!keep) psel <= 1'b0;
        kept = keep;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input bit keep = 1'b0);
        bus(1'b0, a, 32'h0000_0000, keep);
        check(rdat, exp);
    endtask
    task automatic push(input logic [7:0] d, input logic st, input logic pb);
        @(posedge clk);
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        rx_stop_bit <= st;
        rx_parity_bad <= pb;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        rxq.push_back(d);
        repeat (2) @(posedge clk);
    endtask
    task automatic pop;
        rd(`ULS_OFF_RX_DATA, {24'h00_0000, rxq.pop_front()});
        repeat (2) @(posedge clk);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk);
            bit_tick <= 1'b1;
            @(posedge clk);
            bit_tick <= 1'b0;
        end
    endtask
    // 1: transmit fifo empty, 2: shifter idle
    task automatic wt(input int k);
        int n = 0;
        while (n < 200 && !(k == 1 ? tx_fifo_empty === 1'b1 : tx_shift_busy === 1'b0)) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) timeout();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic st;
        logic pb;
        logic [7:0] d;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0060);
        rd(`ULS_OFF_CONTROL, 32'h0000_0000);
        rd(`ULS_OFF_IRQ_MASK, 32'h0000_0000);
        bus(1'b0, 8'h1C, 32'h0000_0000, 1'b0);
        check(rerr, 1'b1);
        $display("test reset finished");
        wr(`ULS_OFF_CONTROL, 32'h0000_0002);
        @(negedge clk);
        check(thr_irq, 1'b1);
        wr(`ULS_OFF_TX_DATA, 32'(rnd8()));
        @(negedge clk);
        check(thr_irq, 1'b0);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0000);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0020);
        @(negedge clk);
        check(thr_irq, 1'b1);
        wt(2);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0060);
        $display("test holding register finished");
        wr(`ULS_OFF_CONTROL, 32'h0000_0003);
        repeat (3) wr(`ULS_OFF_TX_DATA, 32'(rnd8()));
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0000);
        wt(1);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0020);
        wt(2);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0060);
        @(negedge clk);
        check(thr_irq, 1'b1);
        check(fifo_mode, 1'b1);
        $display("test transmit fifo finished");
        for (int m = 0; m < 2; m++) begin
            wr(`ULS_OFF_CONTROL, m == 0 ? 32'h0000_0002 : 32'h0000_0003);
            for (int k = 0; k < 3; k++) begin
                st = k != 1;
                pb = k == 2;
                push(rnd8(), st, pb);
                rd(`ULS_OFF_LINE_STATUS, {24'h00_0000, !st || pb, 3'b110, !st, 3'b000},
                   1'b1);
                rd(`ULS_OFF_LINE_STATUS, 32'h0000_0060);
                pop();
            end
        end
        d = rnd8();
        push(d, 1'b1, 1'b0);
        push(d ^ 8'hA5, 1'b0, 1'b0);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_00E0);
        pop();
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0068);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0060);
        pop();
        $display("test receive flags finished");
        wr(`ULS_OFF_CONTROL, 32'h0000_000D);
        wr(`ULS_OFF_IRQ_STATUS, 32'h0000_000F);
        wr(`ULS_OFF_IRQ_MASK, 32'h0000_0002);
        @(negedge clk);
        check(irq, 1'b0);
        @(posedge clk);
        rx_line <= 1'b0;
        ticks(8);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_0060);
        ticks(16);
        rd(`ULS_OFF_LINE_STATUS, 32'h0000_00F8);
        rxq.push_back(8'h00);
        @(negedge clk);
        check(irq, 1'b1);
        @(posedge clk);
        rx_line <= 1'b1;
        push(rnd8(), 1'b1, 1'b0);
        pop();
        pop();
        wr(`ULS_OFF_IRQ_MASK, 32'h0000_0000);
        @(negedge clk);
        check(irq, 1'b0);
        wr(`ULS_OFF_IRQ_MASK, 32'h0000_0002);
        @(negedge clk);
        check(irq, 1'b1);
        wr(`ULS_OFF_IRQ_STATUS, 32'h0000_0002);
        @(negedge clk);
        check(irq, 1'b0);
        $display("test break and interrupt finished");
        stop_test();
    end
endmodule

bind uls_top uls_top_assertions chk (.*);
`default_nettype wire

// ### test/uls_tx_model.sv
// behavioural transmit fifo and shift register behind the status logic
`timescale 1ns/1ps
`default_nettype none
module uls_tx_model #(
    parameter int SHIFT_CYCLES = 12
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tx_write,
    output var  logic tx_fifo_empty,
    output var  logic tx_shift_load,
    output var  logic tx_shift_busy
);
    int pend;
    int left;
    // a char leaves only when the shifter is free
    wire logic start = pend > 0 && left == 0;

    always_ff @(posedge clk) begin
        if (rst) begin
            pend <= 0;
            left <= 0;
            tx_shift_load <= 1'b0;
        end else begin
            tx_shift_load <= start;
            left <= start ? SHIFT_CYCLES : (left > 0 ? left - 1 : 0);
            pend <= pend + int'(tx_write) - int'(start);
        end
    end
    assign tx_fifo_empty = pend == 0;
    assign tx_shift_busy = left > 0;
endmodule
`default_nettype wire
